// >>> rtl/mad_pkg.sv
// constants and types shared by the measurement averaging, mastering and decimation path
package mad_pkg;
  localparam int SW = 20;
  localparam int OW = 24;
  localparam int MW = 21;
  localparam int NW = 15;
  localparam int RW = 22;
  localparam int AW = 8;
  localparam int MOV_DEPTH = 128;
  localparam int MED_DEPTH = 9;

  // register offsets
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_AVG = 8'h04;
  localparam logic [AW-1:0] A_MVAL = 8'h08;
  localparam logic [AW-1:0] A_RED = 8'h0c;
  localparam logic [AW-1:0] A_CMD = 8'h10;
  localparam logic [AW-1:0] A_STAT = 8'h14;
  localparam logic [AW-1:0] A_OFFS = 8'h18;

  // control bits
  localparam int C_MEN = 0;
  localparam int C_SUBS = 1;
  localparam int C_SUBA = 2;
  localparam int C_KLOCK = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;
  // averaging register fields
  localparam int AVG_MODE_LSB = 16;
  // status bits
  localparam int ST_ACT = 0;
  localparam int ST_ARM = 1;
  localparam int ST_E220 = 2;
  localparam int ST_E602 = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_FLASH = 5;
  localparam int ST_CODE_LSB = 16;
  localparam logic [9:0] ERR_TIMEOUT_CODE = 10'h0dc;
  localparam logic [9:0] ERR_RANGE_CODE = 10'h25a;

  typedef enum logic [1:0] {AVG_NONE = 2'h0, AVG_MOV = 2'h1, AVG_REC = 2'h2, AVG_MED = 2'h3} mad_avg_type;
  typedef enum logic [1:0] {M_IDLE = 2'b01, M_WAIT = 2'b10} mad_mst_type;

  localparam mad_avg_type DEF_MODE = AVG_MED;
  localparam logic [NW-1:0] DEF_N = 15'h0009;
  localparam logic [NW-1:0] MOV_MAX_N = 15'h0080;
  localparam logic [NW-1:0] REC_MIN_N = 15'h0002;
  localparam logic [RW-1:0] RED_MAX_N = 22'h2dc6c0;
  localparam logic [RW-1:0] RED_RST = 22'h000001;

  // times in their own units
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMEOUT_MS = 2000;
  localparam int FLASH_MS = 2000;
  localparam int FLASH_HZ = 8;
  localparam int SEC_MS = 1000;
  localparam int LOCK_MIN = 5;
  localparam logic [8:0] LOCK_SEC = 9'(LOCK_MIN * 60);
endpackage : mad_pkg

// >>> rtl/mad_mov_mean.sv
// moving-mean window over the most recent 2^k samples
module mad_mov_mean
  import mad_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic [SW-1:0] value_i,
  input wire logic [2:0] log2n_i,
  output logic [SW-1:0] mean_o
);
  typedef struct packed {
    logic [MOV_DEPTH-1:0][SW-1:0] buf_q;
    logic [6:0] wp;
    logic [SW+6:0] sum;
  } mad_mov_type;

  mad_mov_type st;
  mad_mov_type next_st;
  logic [6:0] old_idx;

  always_comb
  begin
    next_st = st;
    old_idx = st.wp - 7'(8'h01 << log2n_i);
    if (clear_i)
    begin
      next_st = '0;
    end
    else if (shift_i)
    begin
      next_st.sum = st.sum + (SW+7)'(value_i) - (SW+7)'(st.buf_q[old_idx]);
      next_st.buf_q[st.wp] = value_i;
      next_st.wp = st.wp + 7'h01;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign mean_o = SW'(st.sum >> log2n_i);
endmodule : mad_mov_mean

// >>> rtl/mad_median.sv
// running median over the last 3, 5, 7 or 9 samples
module mad_median
  import mad_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic [SW-1:0] value_i,
  input wire logic [3:0] n_i,
  output logic [SW-1:0] median_o
);
  typedef struct packed {
    logic [MED_DEPTH-1:0][SW-1:0] hist;
  } mad_med_type;

  mad_med_type st;
  mad_med_type next_st;
  logic [MED_DEPTH-1:0][3:0] rank;
  logic [3:0] mid;

  always_comb
  begin
    next_st = st;
    if (clear_i)
      next_st = '0;
    else if (shift_i)
      next_st.hist = {st.hist[MED_DEPTH-2:0], value_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  for (genvar gi = 0; gi < MED_DEPTH; gi++)
  begin : g_rank
    always_comb
    begin
      rank[gi] = 4'h0;
      for (int j = 0; j < MED_DEPTH; j++)
      begin
        if ((4'(j) < n_i) && ((st.hist[j] < st.hist[gi]) || ((st.hist[j] == st.hist[gi]) && (j < gi))))
          rank[gi] = rank[gi] + 4'h1;
      end
    end
  end

  assign mid = (n_i - 4'h1) >> 1;

  always_comb
  begin
    median_o = '0;
    for (int i = 0; i < MED_DEPTH; i++)
    begin
      if ((4'(i) < n_i) && (rank[i] == mid))
        median_o = st.hist[i];
    end
  end
endmodule : mad_median

// >>> rtl/mad_filter_top.sv
// averaging, mastering and decimation stage between displacement calculation and outputs
// How it works
// - mode inactive passes each sample unchanged to the outputs.
// - moving mean accepts N as power of two up to 128.
// - each new sample enters the window, the oldest leaves.
// - recursive mean weights new value against previous output, N 2..32767.
// - median sorts last 3/5/7/9 samples and outputs the middle one.
// - after factory reset the median filter with nine samples is selected.
// - filter sits before outputs and keeps one output per sample.
// - filtered result is recomputed once per measuring cycle.
// - averaging mode and N are held as the retained configuration.
// - mastering shifts output so the mastered position reads the master value.
// - zeroing is mastering with a master value of zero.
// - master command waits 2 s for a sample, else timeout error.
// - invalid captured sample is rejected with out-of-range error.
// - master setting inactive cancels the offset.
// - offset applies to both serial and analog outputs.
// - a refused master request flashes the red indicator 8 Hz for 2 s.
// - select key locks 5 min after lock is enabled; then ignored.
// - data reduction n forwards every nth sample, n 1..3000000.
// - reduction applies only to outputs selected for sub-sampling.
// - mastering is refused unless the target is in range.
module mad_filter_top
  import mad_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS,
  parameter int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS,
  parameter int unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ),
  parameter int unsigned SEC_CYC = CLK_HZ / 1000 * SEC_MS
)
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic sample_valid_i,
  input wire logic [SW-1:0] sample_value_i,
  input wire logic sample_ok_i,
  input wire logic key_i,
  input wire logic func_i,
  output logic serial_valid_o,
  output logic [OW-1:0] serial_value_o,
  output logic analog_valid_o,
  output logic [OW-1:0] analog_value_o,
  output logic led_red_o,
  output logic master_active_o,
  output logic key_locked_o
);
  typedef struct packed {
    mad_avg_type avg_mode;
    logic [NW-1:0] avg_n;
    logic [2:0] mov_log2;
    logic [MW-1:0] master_val;
    logic [RW-1:0] red_n;
    logic [3:0] ctrl;
    logic [SW-1:0] raw;
    logic ok1;
    logic v1;
    logic [SW-1:0] rec;
    logic rec_init;
    mad_mst_type mst;
    logic [OW-1:0] offset;
    logic master_act;
    logic [25:0] tmo;
    logic e220;
    logic e602;
    logic [9:0] last_err;
    logic [25:0] flash_cnt;
    logic [20:0] half_cnt;
    logic led;
    logic key_s1;
    logic key_s2;
    logic key_d;
    logic fn_s1;
    logic fn_s2;
    logic fn_d;
    logic [24:0] sec_cnt;
    logic [8:0] lock_sec;
    logic locked;
    logic [RW-1:0] red_cnt;
    logic s_valid;
    logic [OW-1:0] s_value;
    logic a_valid;
    logic [OW-1:0] a_value;
    logic [31:0] rdata;
  } mad_top_type;

  mad_top_type st;
  mad_top_type next_st;
  logic [SW-1:0] mean;
  logic [SW-1:0] median;
  logic [SW-1:0] filt;
  logic [OW-1:0] out_val;
  logic cfg_clear;
  logic cfg_ok;
  mad_avg_type w_mode;
  logic [NW-1:0] w_n;
  logic [2:0] w_log2;
  logic [35:0] rec_sum;
  logic [35:0] rec_div;
  logic req;
  logic flash_go;
  logic fire;

  mad_mov_mean u_mov (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .clear_i(cfg_clear),
    .shift_i(sample_valid_i),
    .value_i(sample_value_i),
    .log2n_i(st.mov_log2),
    .mean_o(mean)
  );

  mad_median u_med (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .clear_i(cfg_clear),
    .shift_i(sample_valid_i),
    .value_i(sample_value_i),
    .n_i(st.avg_n[3:0]),
    .median_o(median)
  );

  // check a requested averaging configuration
  always_comb
  begin
    w_mode = mad_avg_type'(wdata_i[AVG_MODE_LSB+1:AVG_MODE_LSB]);
    w_n = wdata_i[NW-1:0];
    w_log2 = 3'h0;
    cfg_ok = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      if (w_n == NW'(16'h0001 << k))
        w_log2 = 3'(k);
    end
    case (w_mode)
      AVG_NONE: cfg_ok = 1'b1;
      AVG_MOV: cfg_ok = (w_n != '0) && ((w_n & (w_n - 15'h1)) == '0) && (w_n <= MOV_MAX_N);
      AVG_REC: cfg_ok = (w_n >= REC_MIN_N);
      AVG_MED: cfg_ok = (w_n == 15'h3) || (w_n == 15'h5) || (w_n == 15'h7) || (w_n == 15'h9);
      default: cfg_ok = 1'b0;
    endcase
    cfg_clear = wr_i && (addr_i == A_AVG) && cfg_ok;
  end

  assign rec_div = (st.avg_n == '0) ? 36'h1 : 36'(st.avg_n);
  assign rec_sum = 36'(sample_value_i) + 36'(st.rec) * 36'(st.avg_n - 15'h1);

  always_comb
  begin
    case (st.avg_mode)
      AVG_NONE: filt = st.raw;
      AVG_MOV: filt = mean;
      AVG_REC: filt = st.rec;
      AVG_MED: filt = median;
      default: filt = st.raw;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.rdata = '0;
    req = 1'b0;
    flash_go = 1'b0;
    fire = 1'b0;
    out_val = '0;
    // pin synchronisers
    next_st.key_s1 = key_i;
    next_st.key_s2 = st.key_s1;
    next_st.key_d = st.key_s2;
    next_st.fn_s1 = func_i;
    next_st.fn_s2 = st.fn_s1;
    next_st.fn_d = st.fn_s2;
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        A_CTRL: next_st.ctrl = wdata_i[3:0];
        A_AVG:
        begin
          if (cfg_ok)
          begin
            next_st.avg_mode = w_mode;
            next_st.avg_n = w_n;
            next_st.mov_log2 = w_log2;
            next_st.rec_init = 1'b0;
          end
        end
        // zero is a master value too
        A_MVAL: next_st.master_val = wdata_i[MW-1:0];
        A_RED:
        begin
          if ((wdata_i[RW-1:0] != '0) && (wdata_i[RW-1:0] <= RED_MAX_N) && (wdata_i[31:RW] == '0))
          begin
            next_st.red_n = wdata_i[RW-1:0];
            next_st.red_cnt = '0;
          end
        end
        A_CMD: req = wdata_i[0];
        A_STAT:
        begin
          next_st.e220 = st.e220 & ~wdata_i[ST_E220];
          next_st.e602 = st.e602 & ~wdata_i[ST_E602];
        end
        default: ;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        A_CTRL: next_st.rdata = 32'(st.ctrl);
        A_AVG: next_st.rdata = {14'h0, st.avg_mode, 1'b0, st.avg_n};
        A_MVAL: next_st.rdata = 32'(st.master_val);
        A_RED: next_st.rdata = 32'(st.red_n);
        A_STAT:
        begin
          next_st.rdata[ST_ACT] = st.master_act;
          next_st.rdata[ST_ARM] = (st.mst == M_WAIT);
          next_st.rdata[ST_E220] = st.e220;
          next_st.rdata[ST_E602] = st.e602;
          next_st.rdata[ST_LOCK] = st.locked;
          next_st.rdata[ST_FLASH] = (st.flash_cnt != '0);
          next_st.rdata[ST_CODE_LSB+9:ST_CODE_LSB] = st.last_err;
        end
        A_OFFS: next_st.rdata = 32'(st.offset);
        default: next_st.rdata = '0;
      endcase
    end
    if (!st.ctrl[C_KLOCK])
    begin
      next_st.sec_cnt = '0;
      next_st.lock_sec = '0;
      next_st.locked = 1'b0;
    end
    else if (!st.locked)
    begin
      if (st.sec_cnt == 25'(SEC_CYC - 1))
      begin
        next_st.sec_cnt = '0;
        next_st.lock_sec = st.lock_sec + 9'h1;
        next_st.locked = (st.lock_sec + 9'h1 == LOCK_SEC);
      end
      else
        next_st.sec_cnt = st.sec_cnt + 25'h1;
    end
    req = req | (st.fn_s2 & ~st.fn_d) | (st.key_s2 & ~st.key_d & ~st.locked);
    // stage one: capture and filter update
    next_st.v1 = sample_valid_i;
    if (sample_valid_i)
    begin
      next_st.raw = sample_value_i;
      next_st.ok1 = sample_ok_i;
      next_st.rec_init = 1'b1;
      next_st.rec = st.rec_init ? SW'(rec_sum / rec_div) : sample_value_i;
    end
    // master sequencing
    case (st.mst)
      M_IDLE:
      begin
        if (req && st.ctrl[C_MEN])
        begin
          next_st.mst = M_WAIT;
          next_st.tmo = '0;
        end
        else if (req)
          flash_go = 1'b1;
      end
      M_WAIT:
      begin
        if (st.v1)
        begin
          next_st.mst = M_IDLE;
          if (st.ok1)
          begin
            next_st.offset = OW'(st.master_val) - OW'(filt);
            next_st.master_act = 1'b1;
          end
          else
          begin
            next_st.e602 = 1'b1;
            next_st.last_err = ERR_RANGE_CODE;
            flash_go = 1'b1;
          end
        end
        else if (st.tmo == 26'(TIMEOUT_CYC - 1))
        begin
          next_st.mst = M_IDLE;
          next_st.e220 = 1'b1;
          next_st.last_err = ERR_TIMEOUT_CODE;
          flash_go = 1'b1;
        end
        else
          next_st.tmo = st.tmo + 26'h1;
      end
      default: next_st.mst = M_IDLE;
    endcase
    if (!st.ctrl[C_MEN])
    begin
      next_st.mst = M_IDLE;
      next_st.offset = '0;
      next_st.master_act = 1'b0;
    end
    // red flash 8 Hz for 2 s
    if (flash_go)
    begin
      next_st.flash_cnt = 26'(FLASH_CYC);
      next_st.half_cnt = '0;
      next_st.led = 1'b1;
    end
    else if (st.flash_cnt != '0)
    begin
      next_st.flash_cnt = st.flash_cnt - 26'h1;
      if (st.flash_cnt == 26'h1)
        next_st.led = 1'b0;
      else if (st.half_cnt == 21'(FLASH_HALF_CYC - 1))
      begin
        next_st.half_cnt = '0;
        next_st.led = ~st.led;
      end
      else
        next_st.half_cnt = st.half_cnt + 21'h1;
    end
    out_val = OW'(filt) + next_st.offset;
    next_st.s_valid = 1'b0;
    next_st.a_valid = 1'b0;
    if (st.v1)
    begin
      if (st.red_cnt >= st.red_n - 22'h1)
      begin
        fire = 1'b1;
        next_st.red_cnt = '0;
      end
      else
        next_st.red_cnt = st.red_cnt + 22'h1;
      next_st.s_valid = fire | ~st.ctrl[C_SUBS];
      next_st.a_valid = fire | ~st.ctrl[C_SUBA];
      if (next_st.s_valid)
        next_st.s_value = out_val;
      if (next_st.a_valid)
        next_st.a_value = out_val;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st <= '0;
      st.avg_mode <= DEF_MODE;
      st.avg_n <= DEF_N;
      st.ctrl <= CTRL_RST;
      st.red_n <= RED_RST;
      st.mst <= M_IDLE;
    end
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
  assign serial_valid_o = st.s_valid;
  assign serial_value_o = st.s_value;
  assign analog_valid_o = st.a_valid;
  assign analog_value_o = st.a_value;
  assign led_red_o = st.led;
  assign master_active_o = st.master_act;
  assign key_locked_o = st.locked;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  chk_none_pass: assert property (st.v1 && st.avg_mode == AVG_NONE && !st.ctrl[C_MEN] && !st.ctrl[C_SUBS]
    |=> serial_value_o == OW'($past(st.raw)))
    else $error("inactive filter altered the sample");
  chk_rate_kept: assert property (sample_valid_i && !st.ctrl[C_SUBS] && !wr_i |-> ##2 serial_valid_o)
    else $error("sample produced no serial output");
  chk_one_per_cycle: assert property (serial_valid_o || analog_valid_o |-> $past(st.v1))
    else $error("output without a measuring cycle");
  chk_factory_mode: assert property ($fell(srst_i) |-> st.avg_mode == AVG_MED && st.avg_n == DEF_N)
    else $error("factory setting is not median of nine");
  chk_master_apply: assert property (st.mst == M_WAIT && st.v1 && st.ok1 && st.ctrl[C_MEN] && !st.ctrl[C_SUBS]
    |=> master_active_o && serial_value_o == OW'($past(st.master_val)))
    else $error("mastered output differs from master value");
  chk_timeout_err: assert property (st.mst == M_WAIT && !st.v1 && st.ctrl[C_MEN] && st.tmo == 26'(TIMEOUT_CYC - 1)
    |=> st.e220 && st.mst == M_IDLE && st.flash_cnt == 26'(FLASH_CYC))
    else $error("timeout not reported");
  chk_range_reject: assert property (st.mst == M_WAIT && st.v1 && !st.ok1 && st.ctrl[C_MEN]
    |=> st.e602 && $stable(st.offset) && led_red_o)
    else $error("invalid master sample accepted");
  chk_inactive_clear: assert property (!st.ctrl[C_MEN] |=> st.offset == '0 && !master_active_o)
    else $error("offset kept while mastering inactive");
  chk_key_locked: assert property (st.locked && st.mst == M_IDLE && !(st.fn_s2 && !st.fn_d) && !(wr_i && addr_i == A_CMD)
    |=> st.mst == M_IDLE)
    else $error("locked key armed mastering");
  chk_reduce_gap: assert property (st.v1 && st.ctrl[C_SUBS] && st.red_cnt < st.red_n - 22'h1 && !wr_i
    |=> !serial_valid_o)
    else $error("reduced sample was forwarded");

  cov_master_done: cover property (st.mst == M_WAIT ##1 master_active_o);
  cov_timeout: cover property ($rose(st.e220));
  cov_reduced: cover property (st.ctrl[C_SUBS] && serial_valid_o);
  cov_median: cover property (st.avg_mode == AVG_MED && serial_valid_o);
endmodule : mad_filter_top

// >>> verification/mad_plc_model.sv
// output consumer model: counts forwarded values and keeps the latest of each path
module mad_plc_model
  import mad_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic serial_valid_i,
  input wire logic [OW-1:0] serial_value_i,
  input wire logic analog_valid_i,
  input wire logic [OW-1:0] analog_value_i,
  output logic [OW-1:0] serial_last_o,
  output logic [OW-1:0] analog_last_o,
  output logic [15:0] serial_cnt_o,
  output logic [15:0] analog_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // takes a value only in the cycle its strobe stands
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      serial_cnt_o <= 16'h0000;
      analog_cnt_o <= 16'h0000;
      serial_last_o <= '0;
      analog_last_o <= '0;
    end
    else
    begin
      if (serial_valid_i)
      begin
        serial_cnt_o <= serial_cnt_o + 16'h0001;
        serial_last_o <= serial_value_i;
      end
      if (analog_valid_i)
      begin
        analog_cnt_o <= analog_cnt_o + 16'h0001;
        analog_last_o <= analog_value_i;
      end
    end
  end
endmodule : mad_plc_model

// >>> verification/measurement_averaging_master_decimator_tb_top.sv
// self-checking bench for the averaging, mastering and decimation stage
module measurement_averaging_master_decimator_tb_top
  import mad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic wcfg; logic [31:0] cfg; logic [SW-1:0] v; logic [OW-1:0] exp;} mad_row_type;
  mad_row_type rows [14] = '{
    '{1'b1, 32'h00000001, 20'h12345, 24'h012345}, '{1'b0, 32'h0, 20'hfffff, 24'h0fffff},
    '{1'b1, 32'h00010004, 20'h00004, 24'h000001}, '{1'b0, 32'h0, 20'h00008, 24'h000003},
    '{1'b0, 32'h0, 20'h0000c, 24'h000006}, '{1'b0, 32'h0, 20'h00010, 24'h00000a},
    '{1'b0, 32'h0, 20'h00014, 24'h00000e}, '{1'b1, 32'h00020002, 20'h0000a, 24'h00000a},
    '{1'b0, 32'h0, 20'h00014, 24'h00000f}, '{1'b0, 32'h0, 20'h00000, 24'h000007},
    '{1'b1, 32'h00030003, 20'h00005, 24'h000000}, '{1'b0, 32'h0, 20'h00009, 24'h000005},
    '{1'b0, 32'h0, 20'h00001, 24'h000005}, '{1'b0, 32'h0, 20'h00007, 24'h000007}};

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [AW-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [SW-1:0] sample_value_i = '0;
  logic sample_ok_i = 1'b0;
  logic key_i = 1'b0;
  logic func_i = 1'b0;
  logic [31:0] rdata_o;
  logic serial_valid_o;
  logic analog_valid_o;
  logic [OW-1:0] serial_value_o;
  logic [OW-1:0] analog_value_o;
  logic led_red_o;
  logic master_active_o;
  logic key_locked_o;
  logic [OW-1:0] ser_last;
  logic [OW-1:0] ana_last;
  logic [15:0] ser_cnt;
  logic [15:0] ana_cnt;
  logic [31:0] s;
  logic [15:0] c0;
  logic [15:0] c1;
  logic l0;
  int n_errors = 0;
  int cmp_count = 0;

  always #20 mclk_i = ~mclk_i;

  mad_filter_top #(.TIMEOUT_CYC(200), .FLASH_CYC(160), .FLASH_HALF_CYC(10), .SEC_CYC(8)) DUT (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sample_valid_i(sample_valid_i), .sample_value_i(sample_value_i),
    .sample_ok_i(sample_ok_i), .key_i(key_i), .func_i(func_i), .serial_valid_o(serial_valid_o),
    .serial_value_o(serial_value_o), .analog_valid_o(analog_valid_o), .analog_value_o(analog_value_o),
    .led_red_o(led_red_o), .master_active_o(master_active_o), .key_locked_o(key_locked_o));

  mad_plc_model plc (
    .mclk_i(mclk_i), .srst_i(srst_i), .serial_valid_i(serial_valid_o), .serial_value_i(serial_value_o),
    .analog_valid_i(analog_valid_o), .analog_value_i(analog_value_o), .serial_last_o(ser_last),
    .analog_last_o(ana_last), .serial_cnt_o(ser_cnt), .analog_cnt_o(ana_cnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    s = rdata_o;
  endtask : rd

  task automatic smp(input logic [SW-1:0] v, input logic ok);
    @(posedge mclk_i);
    sample_valid_i <= 1'b1;
    sample_value_i <= v;
    sample_ok_i <= ok;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : smp

  task automatic pulse_pin(input logic is_key);
    if (is_key)
      key_i <= 1'b1;
    else
      func_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    key_i <= 1'b0;
    func_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask : pulse_pin

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (8000) @(posedge mclk_i);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(A_AVG);
    chk(s, 32'h00030009); // factory filter setting
    rd(A_CTRL);
    chk(s, 32'h00000008); // mastering starts inactive
    rd(A_RED);
    chk(s, 32'h00000001); // reduction starts at one
    rd(8'h20);
    chk(s, 32'h0); // unmapped place reads zero
    foreach (rows[i])
    begin
      if (rows[i].wcfg)
        wr(A_AVG, rows[i].cfg);
      smp(rows[i].v, 1'b1);
      chk(ser_last, rows[i].exp); // filter output per sample
    end
    wr(A_AVG, 32'h00010003);
    rd(A_AVG);
    chk(s, 32'h00030003); // non-power window refused
    wr(A_AVG, 32'h00000000);
    wr(A_CTRL, 32'h9);
    wr(A_MVAL, 32'h1f4);
    wr(A_CMD, 32'h1);
    smp(20'h00064, 1'b1);
    chk(ser_last, 24'h0001f4); // mastered sample reads master value
    smp(20'h0006e, 1'b1);
    chk(ser_last, 24'h0001fe); // later samples keep offset
    chk(ana_last, 24'h0001fe); // analog path offset too
    chk(master_active_o, 1'b1); // offset flagged
    rd(A_OFFS);
    chk(s, 32'h00000190); // offset is master minus sample
    repeat (10) @(posedge mclk_i);
    wr(A_MVAL, 32'h0);
    wr(A_CMD, 32'h1);
    smp(20'h000c8, 1'b1);
    chk(ser_last, 24'h000000); // zeroing
    wr(A_CTRL, 32'h8);
    smp(20'h0012c, 1'b1);
    chk(ser_last, 24'h00012c); // offset cancelled
    chk(master_active_o, 1'b0); // flag dropped
    wr(A_CMD, 32'h1);
    rd(A_STAT);
    chk({led_red_o, s[5], s[1]}, 3'b110); // refused request flashes, not armed
    wr(A_CTRL, 32'h9);
    repeat (10) @(posedge mclk_i);
    wr(A_CMD, 32'h1);
    repeat (210) @(posedge mclk_i);
    rd(A_STAT);
    chk({s[25:16], s[5], s[2]}, {ERR_TIMEOUT_CODE, 2'b11}); // timeout error and flash
    #1;
    l0 = led_red_o;
    repeat (10) @(posedge mclk_i);
    #1;
    chk(led_red_o, !l0); // indicator toggles at flash rate
    repeat (170) @(posedge mclk_i);
    wr(A_STAT, 32'h0000000c);
    wr(A_CMD, 32'h1);
    smp(20'h00032, 1'b0);
    rd(A_STAT);
    chk({s[25:16], s[3], s[0]}, {ERR_RANGE_CODE, 2'b10}); // invalid target refused
    chk(master_active_o, 1'b0); // no offset taken
    rd(A_OFFS);
    chk(s, 32'h0); // offset register untouched
    // key still unlocked here, a press must arm mastering
    pulse_pin(1'b1);
    rd(A_STAT);
    chk(s[1], 1'b1); // key arms before lock
    smp(20'h00010, 1'b1);
    chk(ser_last, 24'h000000); // key-started zeroing
    c0 = 16'h0;
    while (key_locked_o !== 1'b1 && c0 < 16'd3000)
    begin
      @(posedge mclk_i);
      c0++;
    end
    rd(A_STAT);
    chk({key_locked_o, s[4]}, 2'b11); // key locked after delay
    repeat (170) @(posedge mclk_i);
    pulse_pin(1'b1);
    rd(A_STAT);
    chk(s[1], 1'b0); // locked key ignored
    pulse_pin(1'b0);
    rd(A_STAT);
    chk(s[1], 1'b1); // function input arms
    smp(20'h00007, 1'b1);
    wr(A_CTRL, 32'ha);
    wr(A_RED, 32'h002dc6c0);
    rd(A_RED);
    chk(s, 32'h002dc6c0); // largest factor accepted
    wr(A_RED, 32'h3);
    wr(A_RED, 32'h0);
    wr(A_RED, 32'h002dc6c1);
    rd(A_RED);
    chk(s, 32'h3); // out-of-range reduction refused
    c0 = ser_cnt;
    c1 = ana_cnt;
    repeat (6) smp(20'h00001, 1'b1);
    chk(ser_cnt - c0, 16'd2); // every third forwarded
    chk(ana_cnt - c1, 16'd6); // unselected path keeps all
    wr(A_CTRL, 32'h4);
    c0 = ser_cnt;
    c1 = ana_cnt;
    repeat (3) smp(20'h00001, 1'b1);
    chk(ser_cnt - c0, 16'd3); // serial unselected keeps all
    chk(ana_cnt - c1, 16'd1); // analog selected is reduced
    wrap_up();
  end
endmodule : measurement_averaging_master_decimator_tb_top
